// ### core/spsq_link.sv
// Link-clock side of the SPI phase sequence block: walks the phases of one communication.
// Assumes the serial engine pulses phase_done_in (with phase_error_in) once per phase on link_clk_in.
`timescale 1ns/1ps
`include "spsq_regs.svh"

module spsq_link
(
  input  wire logic                         link_clk_in,
  input  wire logic                         reset_in,
  input  wire logic                         start_toggle_in,
  input  wire logic [2:0]                   phase_total_in,
  input  wire logic                         phase_done_in,
  input  wire logic                         phase_error_in,
  output spsq_pkg::spsq_end_type            end_out,
  output logic                              phase_start_out,
  output logic [2:0]                        phase_index_out
);
  import spsq_pkg::*;

  // ==========================================================
  // Crossings into the link domain
  logic       rst_s1;
  logic       rst_s2;
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_s3;
  logic [2:0] tot_s1;
  logic [2:0] tot_s2;

  always_ff @(posedge link_clk_in)
  begin
    rst_s1 <= reset_in;
    rst_s2 <= rst_s1;
    tog_s1 <= start_toggle_in;
    tog_s2 <= tog_s1;
    tot_s1 <= phase_total_in;
    tot_s2 <= tot_s1;
  end

  // ==========================================================
  // Phase walker
  spsq_link_state_type state;
  spsq_link_state_type next_state;
  spsq_end_type        next_end;
  logic                next_phase_start;
  logic [2:0]          next_phase_index;
  logic                next_tog_s3;

  always_comb
  begin
    next_state       = state;
    next_end         = end_out;
    next_phase_start = 1'b0;
    next_phase_index = phase_index_out;
    next_tog_s3      = tog_s2;
    case (state)
      SPSQ_LINK_IDLE:
      begin
        if (tog_s2 != tog_s3)
        begin
          next_phase_index = 3'h0;
          next_end.fault   = 1'b0;
          next_phase_start = 1'b1;
          next_state       = SPSQ_LINK_RUN;
        end
      end
      SPSQ_LINK_RUN:
      begin
        if (phase_done_in)
        begin
          next_end.fault = end_out.fault | phase_error_in;
          if (phase_index_out == tot_s2)
          begin
            next_state = SPSQ_LINK_END;
          end
          else
          begin
            next_phase_index = phase_index_out + 3'h1;
            next_phase_start = 1'b1;
          end
        end
      end
      SPSQ_LINK_END:
      begin
        // Fault has been stable a cycle before the toggle flips
        next_end.toggle = ~end_out.toggle;
        next_state      = SPSQ_LINK_IDLE;
      end
      default:
      begin
        next_state = SPSQ_LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_in)
  begin
    if (rst_s2)
    begin
      state           <= SPSQ_LINK_IDLE;
      end_out         <= '0;
      phase_start_out <= 1'b0;
      phase_index_out <= 3'h0;
      tog_s3          <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      end_out         <= next_end;
      phase_start_out <= next_phase_start;
      phase_index_out <= next_phase_index;
      tog_s3          <= next_tog_s3;
    end
  end

endmodule

// ### core/spsq_pkg.sv
// Types shared by the SPI phase sequence block.
// Assumes the constants of spsq_regs.svh for field widths.
package spsq_pkg;

  // ==========================================================
  // State machines
  typedef enum logic [1:0]
  {
    SPSQ_IDLE     = 2'b00,
    SPSQ_SERIAL   = 2'b01,
    SPSQ_DMA_WAIT = 2'b10
  } spsq_state_type;

  typedef enum logic [1:0]
  {
    SPSQ_LINK_IDLE = 2'b00,
    SPSQ_LINK_RUN  = 2'b01,
    SPSQ_LINK_END  = 2'b10
  } spsq_link_state_type;

  // ==========================================================
  // Carriers
  typedef struct packed
  {
    logic       dma_last;
    logic [2:0] phase_total;
    logic       fault;
    logic       complete;
  } spsq_ctrl_type;

  typedef struct packed
  {
    logic toggle;
    logic fault;
  } spsq_end_type;

endpackage

// ### core/spsq_regs.svh
// Register offsets, bit positions and reset values of the SPI phase sequence block.
// Assumes a 32-bit APB register bus with a 12-bit byte address.
`ifndef SPSQ_REGS_SVH
`define SPSQ_REGS_SVH

// ==========================================================
// Register map
`define SPSQ_ADDR_W        12
`define SPSQ_CTRL_OFFSET   12'h000
`define SPSQ_STAT_OFFSET   12'h004

// ==========================================================
// Control and status fields
`define SPSQ_GO_BIT        0
`define SPSQ_DONE_BIT      1
`define SPSQ_FAULT_BIT     2
`define SPSQ_TOTAL_LSB     4
`define SPSQ_TOTAL_MSB     6
`define SPSQ_DMA_BIT       8
`define SPSQ_BUSY_BIT      0
`define SPSQ_TOTAL_RESET   3'h0
`define SPSQ_FLAG_RESET    1'b0
`define SPSQ_DATA_RESET    32'h0000_0000

`endif

// ### core/spsq_top.sv
// Sequence control and status of a multi-phase SPI master, with an APB register slave.
// Assumes a phase engine on link_clk_in and a DMA engine that pulses dma_done_in on clk_in.
`timescale 1ns/1ps
`include "spsq_regs.svh"

module spsq_top
(
  input  wire logic                         clk_in,
  input  wire logic                         reset_in,
  input  wire logic                         link_clk_in,
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [`SPSQ_ADDR_W-1:0]      paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  output logic [31:0]                       prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  input  wire logic                         dma_done_in,
  input  wire logic                         phase_done_in,
  input  wire logic                         phase_error_in,
  output logic                              phase_start_out,
  output logic [2:0]                        phase_index_out,
  output logic                              dma_enable_out,
  output logic                              busy_out
);
  import spsq_pkg::*;

  // ==========================================================
  // Link side
  spsq_end_type link_end;
  logic         start_toggle;
  logic [2:0]   phase_total;

  spsq_link u_link
  (
    .link_clk_in     (link_clk_in),
    .reset_in        (reset_in),
    .start_toggle_in (start_toggle),
    .phase_total_in  (phase_total),
    .phase_done_in   (phase_done_in),
    .phase_error_in  (phase_error_in),
    .end_out         (link_end),
    .phase_start_out (phase_start_out),
    .phase_index_out (phase_index_out)
  );

  // ==========================================================
  // End-of-serial crossing
  // An extra toggle stage gives the fault level a spare cycle to settle
  logic end_s1;
  logic end_s2;
  logic end_s3;
  logic end_s4;
  logic flt_s1;
  logic flt_s2;
  logic serial_end;

  always_ff @(posedge clk_in)
  begin
    end_s1 <= link_end.toggle;
    end_s2 <= end_s1;
    end_s3 <= end_s2;
    flt_s1 <= link_end.fault;
    flt_s2 <= flt_s1;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      end_s4 <= 1'b0;
    end
    else
    begin
      end_s4 <= end_s3;
    end
  end

  assign serial_end = end_s3 ^ end_s4;

  // ==========================================================
  // APB slave
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        access_first;
  logic        wr_fire;
  spsq_ctrl_type  ctrl;
  spsq_state_type state;

  always_comb
  begin
    hit_ctrl     = 1'b0;
    hit_stat     = 1'b0;
    if (paddr_in == `SPSQ_CTRL_OFFSET)
    begin
      hit_ctrl = 1'b1;
    end
    else if (paddr_in == `SPSQ_STAT_OFFSET)
    begin
      hit_stat = 1'b1;
    end
    access_first = psel_in & penable_in & ~pready_out;
    wr_fire      = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
    next_pready  = access_first;
    next_pslverr = access_first & ~(hit_ctrl | hit_stat);
    next_prdata  = prdata_out;
    if (access_first)
    begin
      next_prdata = `SPSQ_DATA_RESET;
      if (!pwrite_in && hit_ctrl)
      begin
        next_prdata[`SPSQ_DONE_BIT]                   = ctrl.complete;
        next_prdata[`SPSQ_FAULT_BIT]                  = ctrl.fault;
        next_prdata[`SPSQ_TOTAL_MSB:`SPSQ_TOTAL_LSB]  = ctrl.phase_total;
        next_prdata[`SPSQ_DMA_BIT]                    = ctrl.dma_last;
      end
      else if (!pwrite_in && hit_stat)
      begin
        next_prdata[`SPSQ_BUSY_BIT] = busy_out;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= `SPSQ_DATA_RESET;
    end
    else
    begin
      pready_out  <= next_pready;
      pslverr_out <= next_pslverr;
      prdata_out  <= next_prdata;
    end
  end

  // ==========================================================
  // Sequence control
  spsq_state_type next_state;
  spsq_ctrl_type  next_ctrl;
  logic           next_start_toggle;
  logic           next_busy;
  logic           next_dma_enable;
  logic           dma_seen;
  logic           next_dma_seen;
  logic           serial_fault;
  logic           next_serial_fault;
  logic           go_write;
  logic           dma_needed;
  logic           finish;

  always_comb
  begin
    next_state        = state;
    next_ctrl         = ctrl;
    next_start_toggle = start_toggle;
    next_dma_seen     = dma_seen | dma_done_in;
    next_serial_fault = serial_fault;
    finish            = 1'b0;
    // Go is ignored while a communication runs; setup stays locked too
    go_write   = wr_fire & hit_ctrl & pwdata_in[`SPSQ_GO_BIT] & (state == SPSQ_IDLE);
    // Single-phase DMA is forbidden, so it never holds up completion
    dma_needed = ctrl.dma_last & (ctrl.phase_total != `SPSQ_TOTAL_RESET);

    if (wr_fire && hit_ctrl)
    begin
      if (!pwdata_in[`SPSQ_FAULT_BIT])
      begin
        next_ctrl.fault = 1'b0;
      end
      if (!pwdata_in[`SPSQ_DONE_BIT])
      begin
        next_ctrl.complete = 1'b0;
      end
      if (state == SPSQ_IDLE)
      begin
        next_ctrl.phase_total = pwdata_in[`SPSQ_TOTAL_MSB:`SPSQ_TOTAL_LSB];
        next_ctrl.dma_last    = pwdata_in[`SPSQ_DMA_BIT];
      end
    end

    if (go_write)
    begin
      next_ctrl.fault    = 1'b0;
      next_ctrl.complete = 1'b0;
      next_dma_seen      = 1'b0;
      next_start_toggle  = ~start_toggle;
      next_state         = SPSQ_SERIAL;
    end

    case (state)
      SPSQ_IDLE:
      begin
      end
      SPSQ_SERIAL:
      begin
        if (serial_end)
        begin
          next_serial_fault = flt_s2;
          if (dma_needed && !(dma_seen || dma_done_in))
          begin
            next_state = SPSQ_DMA_WAIT;
          end
          else
          begin
            finish = 1'b1;
          end
        end
      end
      SPSQ_DMA_WAIT:
      begin
        if (dma_seen || dma_done_in)
        begin
          finish = 1'b1;
        end
      end
      default:
      begin
        next_state = SPSQ_IDLE;
      end
    endcase

    // Setting wins over a clear written in the same cycle
    if (finish)
    begin
      next_state         = SPSQ_IDLE;
      next_ctrl.complete = 1'b1;
      if ((state == SPSQ_SERIAL) ? flt_s2 : serial_fault)
      begin
        next_ctrl.fault = 1'b1;
      end
    end

    next_busy       = (next_state != SPSQ_IDLE);
    next_dma_enable = next_ctrl.dma_last & (next_ctrl.phase_total != `SPSQ_TOTAL_RESET);
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state          <= SPSQ_IDLE;
      ctrl.dma_last  <= `SPSQ_FLAG_RESET;
      ctrl.phase_total <= `SPSQ_TOTAL_RESET;
      ctrl.fault     <= `SPSQ_FLAG_RESET;
      ctrl.complete  <= `SPSQ_FLAG_RESET;
      start_toggle   <= 1'b0;
      dma_seen       <= 1'b0;
      serial_fault   <= 1'b0;
      busy_out       <= 1'b0;
      dma_enable_out <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      ctrl           <= next_ctrl;
      start_toggle   <= next_start_toggle;
      dma_seen       <= next_dma_seen;
      serial_fault   <= next_serial_fault;
      busy_out       <= next_busy;
      dma_enable_out <= next_dma_enable;
    end
  end

  assign phase_total = ctrl.phase_total;

endmodule

// ### verif/spsq_phase_model.sv
// Behavioural serial engine: answers each phase start with one done pulse.
// Assumes phase_start_in is a one-cycle pulse on link_clk_in.
`timescale 1ns/1ps

module spsq_phase_model
(
  input  wire logic       link_clk_in,
  input  wire logic       phase_start_in,
  input  wire logic [2:0] phase_index_in,
  input  wire logic [7:0] error_mask_in,
  input  wire logic       slow_in,
  output logic            phase_done_out,
  output logic            phase_error_out
);
  logic [2:0] index;

  initial
  begin
    phase_done_out  = 1'h0;
    phase_error_out = 1'h0;
    forever
    begin
      @(posedge link_clk_in);
      // Error line is only valid with done, so it wanders otherwise
      phase_error_out <= ~phase_error_out;
      if (phase_start_in)
      begin
        index = phase_index_in;
        repeat (slow_in ? 6 : 1) @(posedge link_clk_in);
        phase_done_out  <= 1'h1;
        phase_error_out <= error_mask_in[index];
        @(posedge link_clk_in);
        phase_done_out  <= 1'h0;
        phase_error_out <= ~error_mask_in[index];
      end
    end
  end
endmodule

// ### verif/spsq_top_monitor.sv
// Assertion checker on the APB side of spsq_top.
// Assumes a bind from the bench; sees only core-clock ports of the top module.
`timescale 1ns/1ps
`include "spsq_regs.svh"

module spsq_top_monitor
(
  input wire logic                    clk_in,
  input wire logic                    reset_in,
  input wire logic                    psel_in,
  input wire logic                    penable_in,
  input wire logic                    pwrite_in,
  input wire logic [`SPSQ_ADDR_W-1:0] paddr_in,
  input wire logic [31:0]             pwdata_in,
  input wire logic [31:0]             prdata_out,
  input wire logic                    pready_out,
  input wire logic                    pslverr_out,
  input wire logic                    busy_out
);
  logic mapped;
  logic rd_ok;

  assign mapped = paddr_in == `SPSQ_CTRL_OFFSET || paddr_in == `SPSQ_STAT_OFFSET;
  assign rd_ok  = pready_out && !pwrite_in;

  default clocking mon_cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  // ==========================================================
  // Bus answer
  pready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready held over one cycle");
  pready_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready not after one wait state");
  slverr_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (pready_out && !mapped |-> pslverr_out && (pwrite_in || prdata_out == 32'h0000_0000))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready_out && mapped |-> !pslverr_out)
    else $error("mapped access refused");

  // ==========================================================
  // Register contents
  ctrl_layout_a: assert property (rd_ok && paddr_in == `SPSQ_CTRL_OFFSET |-> prdata_out[0] == 1'h0 && prdata_out[3] == 1'h0 && prdata_out[7] == 1'h0 && prdata_out[31:9] == 23'h0)
    else $error("control read shows go or reserved bits");
  status_layout_a: assert property (rd_ok && paddr_in == `SPSQ_STAT_OFFSET |-> prdata_out[31:1] == 31'h0)
    else $error("status read shows reserved bits");
  go_starts_a: assert property (pready_out && pwrite_in && paddr_in == `SPSQ_CTRL_OFFSET && pwdata_in[0] && !busy_out |=> busy_out)
    else $error("go write did not start");

  cover property ($rose(busy_out));
  cover property ($fell(busy_out));
  cover property (pslverr_out);
endmodule

// ### verif/tb.sv
// Self-checking bench of spsq_top with an APB master, phase model and DMA stub.
// Assumes the monitor and the phase model are compiled first.
`timescale 1ns/1ps
`include "spsq_regs.svh"

module tb;
  logic                    clk_in, link_clk_in, reset_in, dma_done_in, psel_in, penable_in, pwrite_in;
  logic                    pready_out, pslverr_out, phase_done_in, phase_error_in, phase_start_out;
  logic                    dma_enable_out, busy_out, er, slow, dma;
  logic [`SPSQ_ADDR_W-1:0] paddr_in;
  logic [31:0]             pwdata_in, prdata_out, rd, exp;
  logic [2:0]              phase_index_out;
  logic [7:0]              mask;
  logic [15:0]             seed;
  int                      err_total = 0, compares = 0, starts = 0, dones = 0, base_s, base_d, k;

  spsq_top DUT (.clk_in(clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .dma_done_in(dma_done_in),
    .phase_done_in(phase_done_in), .phase_error_in(phase_error_in), .phase_start_out(phase_start_out),
    .phase_index_out(phase_index_out), .dma_enable_out(dma_enable_out), .busy_out(busy_out));

  spsq_phase_model peer (.link_clk_in(link_clk_in), .phase_start_in(phase_start_out),
    .phase_index_in(phase_index_out), .error_mask_in(mask), .slow_in(slow),
    .phase_done_out(phase_done_in), .phase_error_out(phase_error_in));

  initial
  begin
    clk_in = 1'h0;
    forever #25 clk_in = ~clk_in;
  end

  initial
  begin
    link_clk_in = 1'h0;
    #1.7;
    forever #3 link_clk_in = ~link_clk_in;
  end

  always @(posedge link_clk_in)
  begin
    starts <= starts + int'(phase_start_out === 1'h1);
    dones  <= dones + int'(phase_done_in === 1'h1);
  end

  // ==========================================================
  // Expectations and bus tasks
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] ctrl_word(input logic d, input logic [2:0] t, input logic f, input logic c);
    ctrl_word = {23'h0, d, 1'h0, t, 1'h0, f, c, 1'h0};
  endfunction

  function automatic logic exp_fault(input logic [7:0] m, input logic [2:0] t);
    exp_fault = |(m & (8'hff >> (3'h7 - t)));
  endfunction

  task automatic conclude;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want)
    begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask

  // Bounded wait of one clock; running out ends the run
  task automatic guard(inout int n);
    @(posedge clk_in);
    n++;
    if (n > 3000)
    begin
      err_total++;
      $display("ERROR %0t wait timed out", $time);
      conclude;
    end
  endtask

  task automatic apb(input logic wr, input logic [`SPSQ_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in   <= 1'h1;
    pwrite_in <= wr;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do
      guard(n);
    while (pready_out !== 1'h1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'h0;
    penable_in <= 1'h0;
    @(posedge clk_in);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    reset_in    = 1'h1;
    dma_done_in = 1'h0;
    psel_in     = 1'h0;
    penable_in  = 1'h0;
    pwrite_in   = 1'h0;
    paddr_in    = '0;
    pwdata_in   = 32'h0000_0000;
    mask        = 8'h00;
    slow        = 1'h0;
    seed        = 16'h002c;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'h0;
    repeat (4) @(posedge clk_in);
    apb(1'h0, `SPSQ_CTRL_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'h1, 12'h00c, 32'hffff_ffff);
    apb(1'h0, 12'h008, 32'h0000_0000);
    check({rd[30:0], er}, 32'h0000_0001);
    for (int n = 0; n < 8; n++)
    begin
      seed = lfsr(seed);
      mask <= seed[7:0];
      slow <= seed[8];
      dma = n != 0 && seed[9];
      // Flag bits written as one keep the old flags, so here only the go write clears them
      apb(1'h1, `SPSQ_CTRL_OFFSET, ctrl_word(dma, 3'(n), 1'h1, 1'h1));
      base_s = starts;
      base_d = dones;
      apb(1'h1, `SPSQ_CTRL_OFFSET, ctrl_word(dma, 3'(n), 1'h1, 1'h1) | 32'h0000_0001);
      apb(1'h0, `SPSQ_CTRL_OFFSET, 32'h0000_0000);
      check(rd, ctrl_word(dma, 3'(n), 1'h0, 1'h0));
      check(32'(dma_enable_out), 32'(dma));
      k = 0;
      while (dones - base_d != n + 1)
        guard(k);
      repeat (20) @(posedge clk_in);
      if (dma)
      begin
        apb(1'h0, `SPSQ_CTRL_OFFSET, 32'h0000_0000);
        check(rd, ctrl_word(1'h1, 3'(n), 1'h0, 1'h0));
        apb(1'h0, `SPSQ_STAT_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        dma_done_in <= 1'h1;
        @(posedge clk_in);
        dma_done_in <= 1'h0;
      end
      while (busy_out !== 1'h0)
        guard(k);
      check(32'(starts - base_s), 32'(n + 1));
      exp = ctrl_word(dma, 3'(n), exp_fault(mask, 3'(n)), 1'h1);
      apb(1'h0, `SPSQ_CTRL_OFFSET, 32'h0000_0000);
      check(rd, exp);
      apb(1'h1, `SPSQ_CTRL_OFFSET, ctrl_word(dma, 3'(n), 1'h1, 1'h1));
      apb(1'h0, `SPSQ_CTRL_OFFSET, 32'h0000_0000);
      check(rd, exp);
      // Clear one flag at a time so the next go has the other one to clear
      apb(1'h1, `SPSQ_CTRL_OFFSET, ctrl_word(dma, 3'(n), n[0], !n[0]));
      apb(1'h0, `SPSQ_CTRL_OFFSET, 32'h0000_0000);
      check(rd, exp & ctrl_word(1'h1, 3'h7, n[0], !n[0]));
    end
    apb(1'h1, `SPSQ_CTRL_OFFSET, 32'h0000_0000);
    apb(1'h0, `SPSQ_CTRL_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    conclude;
  end
endmodule

bind spsq_top spsq_top_monitor u_mon (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .busy_out(busy_out));
